// [hpp_pkg.sv]
package hpp_pkg;
	// clock and timing
	localparam int CLK_NS = 5;
	localparam int RBD_NS = 15;
	localparam int RBD_CYC = (RBD_NS + CLK_NS - 1) / CLK_NS;
	// register indices; byte address is four times the index
	localparam logic [11:0] IDX_PORT_CTRL = 12'h140;
	localparam logic [11:0] IDX_CFG_FIRST = 12'h150;
	localparam logic [11:0] IDX_CFG_OPT = 12'h152;
	localparam logic [11:0] IDX_CFG_LAST = 12'h153;
	localparam logic [11:0] IDX_ERR_CNT = 12'h30D;
	localparam logic [11:0] IDX_ERR_CODE = 12'h30E;
	// port type field values
	localparam logic [7:0] PT_WIDE = 8'h08;
	localparam logic [7:0] PT_NARROW = 8'h09;
	// reset values
	localparam logic [7:0] PORT_CTRL_RST = 8'h08;
	localparam logic [7:0] CFG_OPT_RST = 8'h00;
	// option bits in the option register
	localparam int CFG_RBD_BIT = 0;
	localparam int CFG_WRISE_BIT = 1;
	// error causes
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_ODD_NO_BHE = 8'h01;
	localparam logic [7:0] ERR_WR_ABORT = 8'h02;
	localparam logic [7:0] ERR_RD_ABORT = 8'h03;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WR_BUSY = 3'b001,
		ST_WR_HOLD = 3'b010,
		ST_WR_POST = 3'b011,
		ST_RD_WAIT = 3'b100,
		ST_RD_EXEC = 3'b101,
		ST_RD_HOLD = 3'b110,
		ST_IGNORE = 3'b111
	} hp_state_t;
endpackage

// [mem_bus_if.sv]
`timescale 1ns/1ps
interface mem_bus_if #(parameter int AW = 15);
	logic [AW-1:0] addr;
	logic [15:0] wdata;
	logic [1:0] be;
	logic we;
	logic re;
	logic [15:0] rdata;
	modport master (output addr, output wdata, output be, output we, output re, input rdata);
	modport slave (input addr, input wdata, input be, input we, input re, output rdata);
endinterface

// [strobe_sync.sv]
`timescale 1ns/1ps
module strobe_sync #(
	parameter int W = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// levels
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_state_t;
	sync_state_t r;
	sync_state_t r_nxt;
	// first stage feeds only the second stage
	always_comb begin
		r_nxt = r;
		for (int i = 0; i < W; i++) begin
			r_nxt.s1[i] = din[i];
			r_nxt.s2[i] = r.s1[i];
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
		end else begin
			r <= r_nxt;
		end
	end
	assign dout = r.s2;
endmodule

// [port_mem.sv]
`timescale 1ns/1ps
module port_mem #(
	parameter int AW = 15
) (
	// clock
	input wire logic clk,
	// access
	mem_bus_if.slave bus
);
	genvar g;
	// one byte array per lane, so no array has two writing processes
	generate
		for (g = 0; g < 2; g++) begin : g_lane
			logic [7:0] mem [0:(1<<AW)-1];
			logic [7:0] rd_r;
			always_ff @(posedge clk) begin
				if (bus.we && bus.be[g]) begin
					mem[bus.addr] <= bus.wdata[g*8 +: 8];
				end
				if (bus.re) begin
					rd_r <= mem[bus.addr];
				end
			end
		end
	endgenerate
	assign bus.rdata = {g_lane[1].rd_r, g_lane[0].rd_r};
endmodule

// [host_parallel_port.sv]
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module host_parallel_port #(
	parameter int MEM_AW = 15,
	parameter int WR_CYC = 4,
	parameter int RD_CYC = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// apb register port
	input wire logic [13:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// host port
	input wire logic chip_select_n,
	input wire logic [15:0] adr,
	input wire logic byte_high_enable_n,
	input wire logic fetch_n,
	input wire logic store_n,
	input wire logic [15:0] data_in,
	output logic [15:0] data_out,
	output logic data_oe,
	output logic busy_n,
	output logic busy_oe
);
	typedef struct packed {
		hpp_pkg::hp_state_t st;
		logic busy;
		logic busy_oe;
		logic [15:0] dout;
		logic doe;
		logic [15:0] adr;
		logic byte_high_enable;
		logic [15:0] wdat;
		logic wgo;
		logic wpend;
		logic [7:0] wcnt;
		logic [MEM_AW-1:0] waddr;
		logic [1:0] wbe;
		logic [15:0] wword;
		logic mwe;
		logic mre;
		logic [7:0] rcnt;
		logic cs_q;
		logic rd_q;
		logic wr_q;
		logic [7:0] ctrl;
		logic [7:0] cfg;
		logic [7:0] ecnt;
		logic [7:0] ecode;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} port_state_t;

	localparam port_state_t RST_STATE = '{
		st: hpp_pkg::ST_IDLE,
		ctrl: hpp_pkg::PORT_CTRL_RST,
		cfg: hpp_pkg::CFG_OPT_RST,
		ecode: hpp_pkg::ERR_NONE,
		default: '0
	};
	localparam logic [7:0] WR_LOAD = 8'(WR_CYC - 1);
	localparam logic [7:0] RD_LOAD = 8'(RD_CYC - 1);
	localparam logic [7:0] RBD_LOAD = 8'(hpp_pkg::RBD_CYC);

	port_state_t r;
	port_state_t r_nxt;
	logic [2:0] strobe_s;
	logic cs_s;
	logic rd_s;
	logic wr_s;
	logic narrow;
	logic wide;
	logic invalid;
	logic wr_start;
	logic rd_start;
	logic wr_abort;
	logic rd_abort;
	logic err_evt;
	logic [7:0] err_cause;
	logic [11:0] idx;
	logic mapped;
	logic [31:0] rd_val;

	mem_bus_if #(.AW(MEM_AW)) mbus ();

	// strobes are asynchronous, so they are synchronised; only ST_WR_POST also samples the raw store_n and chip_select_n
	strobe_sync #(.W(3)) u_sync (
		.clk(clk),
		.nrst(nrst),
		.din({~chip_select_n, ~fetch_n, ~store_n}),
		.dout(strobe_s)
	);

	port_mem #(.AW(MEM_AW)) u_mem (
		.clk(clk),
		.bus(mbus.slave)
	);

	assign cs_s = strobe_s[2];
	assign rd_s = strobe_s[1];
	assign wr_s = strobe_s[0];

	// lane placement of a read word
	function automatic logic [15:0] read_lanes(input logic [15:0] w, input logic a0,
			input logic byte_high_enable, input logic nar);
		logic [15:0] v;
		v = w;
		if (nar) begin
			v = {8'h00, a0 ? w[15:8] : w[7:0]};
		end else if (!a0 && !byte_high_enable) begin
			v = {w[7:0], w[7:0]};
		end else if (a0) begin
			v = {w[15:8], w[15:8]};
		end
		return v;
	endfunction

	// byte enables of an access; bit 0 is the even, low byte
	function automatic logic [1:0] lane_enables(input logic a0, input logic byte_high_enable, input logic nar);
		logic [1:0] e;
		e = 2'b11;
		if (nar || (!a0 && !byte_high_enable)) begin
			e = a0 ? 2'b10 : 2'b01;
		end else if (a0) begin
			e = 2'b10;
		end
		return e;
	endfunction

	assign narrow = (r.ctrl == hpp_pkg::PT_NARROW);
	assign wide = (r.ctrl == hpp_pkg::PT_WIDE);
	// word-only hosts tie both low and get halfwords in the wide port type
	assign invalid = wide && adr[0] && byte_high_enable_n;
	assign wr_start = (narrow || wide) && cs_s && wr_s && !r.wr_q;
	assign rd_start = (narrow || wide) && cs_s && rd_s && !r.rd_q;
	assign wr_abort = !wr_s || !cs_s;
	assign rd_abort = !rd_s || !cs_s;

	assign idx = paddr[13:2];
	assign mapped = (paddr[1:0] == 2'b00) && (idx == hpp_pkg::IDX_PORT_CTRL
		|| (idx >= hpp_pkg::IDX_CFG_FIRST && idx <= hpp_pkg::IDX_CFG_LAST)
		|| idx == hpp_pkg::IDX_ERR_CNT || idx == hpp_pkg::IDX_ERR_CODE);

	always_comb begin
		rd_val = 32'h0000_0000;
		if (idx == hpp_pkg::IDX_PORT_CTRL) begin
			rd_val = {24'h00_0000, r.ctrl};
		end else if (idx == hpp_pkg::IDX_CFG_OPT) begin
			rd_val = {24'h00_0000, r.cfg};
		end else if (idx == hpp_pkg::IDX_ERR_CNT) begin
			rd_val = {24'h00_0000, r.ecnt};
		end else if (idx == hpp_pkg::IDX_ERR_CODE) begin
			rd_val = {24'h00_0000, r.ecode};
		end
	end

	always_comb begin
		r_nxt = r;
		err_evt = 1'b0;
		err_cause = hpp_pkg::ERR_NONE;
		r_nxt.mwe = 1'b0;
		r_nxt.mre = 1'b0;
		r_nxt.cs_q = cs_s;
		r_nxt.rd_q = rd_s;
		r_nxt.wr_q = wr_s;

		// background write engine, shared by both write options
		if (r.wpend) begin
			if (r.wcnt == 8'h00) begin
				r_nxt.mwe = 1'b1;
				r_nxt.wpend = 1'b0;
			end else begin
				r_nxt.wcnt = r.wcnt - 8'h01;
			end
		end

		unique case (r.st)
			hpp_pkg::ST_IDLE: begin
				if (wr_start || rd_start) begin
					r_nxt.adr = adr;
					r_nxt.byte_high_enable = !byte_high_enable_n;
					r_nxt.wdat = narrow ? {data_in[7:0], data_in[7:0]} : data_in;
					r_nxt.wgo = 1'b0;
					if (invalid) begin
						err_evt = 1'b1;
						err_cause = hpp_pkg::ERR_ODD_NO_BHE;
						r_nxt.st = hpp_pkg::ST_IGNORE;
					end else if (rd_start) begin
						r_nxt.st = hpp_pkg::ST_RD_WAIT;
					end else if (r.cfg[hpp_pkg::CFG_WRISE_BIT]) begin
						r_nxt.st = hpp_pkg::ST_WR_POST;
					end else begin
						r_nxt.st = hpp_pkg::ST_WR_BUSY;
					end
				end
			end
			hpp_pkg::ST_WR_BUSY: begin
				// write starts at the strobe fall, after any older write drains
				if (!r.wgo && !r.wpend) begin
					r_nxt.wgo = 1'b1;
					r_nxt.wpend = 1'b1;
					r_nxt.wcnt = WR_LOAD;
					r_nxt.waddr = r.adr[MEM_AW:1];
					r_nxt.wbe = lane_enables(r.adr[0], r.byte_high_enable, narrow);
					r_nxt.wword = r.wdat;
				end
				if (wr_abort) begin
					err_evt = 1'b1;
					err_cause = hpp_pkg::ERR_WR_ABORT;
					r_nxt.st = hpp_pkg::ST_IDLE;
				end else if (r.wgo && !r.wpend) begin
					r_nxt.st = hpp_pkg::ST_WR_HOLD;
				end
			end
			hpp_pkg::ST_WR_HOLD: begin
				if (wr_abort) begin
					r_nxt.st = hpp_pkg::ST_IDLE;
				end
			end
			hpp_pkg::ST_WR_POST: begin
				// data is taken late, while the raw strobe is still low
				if (!store_n && !chip_select_n) begin
					r_nxt.adr = adr;
					r_nxt.byte_high_enable = !byte_high_enable_n;
					r_nxt.wdat = narrow ? {data_in[7:0], data_in[7:0]} : data_in;
				end
				if (wr_abort) begin
					r_nxt.st = hpp_pkg::ST_IDLE;
					if (r.wpend) begin
						err_evt = 1'b1;
						err_cause = hpp_pkg::ERR_WR_ABORT;
					end else begin
						r_nxt.wpend = 1'b1;
						r_nxt.wcnt = WR_LOAD;
						r_nxt.waddr = r.adr[MEM_AW:1];
						r_nxt.wbe = lane_enables(r.adr[0], r.byte_high_enable, narrow);
						r_nxt.wword = r.wdat;
					end
				end
			end
			hpp_pkg::ST_RD_WAIT: begin
				if (rd_abort) begin
					err_evt = 1'b1;
					err_cause = hpp_pkg::ERR_RD_ABORT;
					r_nxt.st = hpp_pkg::ST_IDLE;
				end else if (!r.wpend) begin
					r_nxt.mre = 1'b1;
					r_nxt.rcnt = r.cfg[hpp_pkg::CFG_RBD_BIT] ? RD_LOAD + RBD_LOAD : RD_LOAD;
					r_nxt.st = hpp_pkg::ST_RD_EXEC;
				end
			end
			hpp_pkg::ST_RD_EXEC: begin
				r_nxt.dout = read_lanes(mbus.rdata, r.adr[0], r.byte_high_enable, narrow);
				if (rd_abort) begin
					err_evt = 1'b1;
					err_cause = hpp_pkg::ERR_RD_ABORT;
					r_nxt.st = hpp_pkg::ST_IDLE;
				end else if (r.rcnt == 8'h00) begin
					r_nxt.st = hpp_pkg::ST_RD_HOLD;
				end else begin
					r_nxt.rcnt = r.rcnt - 8'h01;
				end
			end
			hpp_pkg::ST_RD_HOLD: begin
				// dout is frozen here until the host ends the read
				if (rd_abort) begin
					r_nxt.st = hpp_pkg::ST_IDLE;
				end
			end
			hpp_pkg::ST_IGNORE: begin
				if (!cs_s || (!rd_s && !wr_s)) begin
					r_nxt.st = hpp_pkg::ST_IDLE;
				end
			end
		endcase

		// busy only while select is seen; pending writes stall the next access
		r_nxt.busy_oe = cs_s;
		r_nxt.busy = cs_s && (r_nxt.st == hpp_pkg::ST_WR_BUSY
			|| (r_nxt.st == hpp_pkg::ST_WR_POST && r_nxt.wpend)
			|| r_nxt.st == hpp_pkg::ST_RD_WAIT
			|| r_nxt.st == hpp_pkg::ST_RD_EXEC);
		r_nxt.doe = cs_s && rd_s;

		if (err_evt) begin
			r_nxt.ecode = err_cause;
			if (r.ecnt != 8'hFF) begin
				r_nxt.ecnt = r.ecnt + 8'h01;
			end
		end

		// apb: one wait state, writes commit on the edge that sees pready
		r_nxt.pready = 1'b0;
		r_nxt.pslverr = 1'b0;
		if (psel && penable && !r.pready) begin
			r_nxt.pready = 1'b1;
			r_nxt.pslverr = !mapped;
			if (!pwrite) begin
				r_nxt.prdata = mapped ? rd_val : 32'h0000_0000;
			end
		end
		if (psel && penable && r.pready && pwrite && mapped) begin
			if (idx == hpp_pkg::IDX_PORT_CTRL) begin
				r_nxt.ctrl = pwdata[7:0];
			end else if (idx == hpp_pkg::IDX_CFG_OPT) begin
				r_nxt.cfg = pwdata[7:0];
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r <= RST_STATE;
		end else begin
			r <= r_nxt;
		end
	end

	assign mbus.addr = r.mre ? r.adr[MEM_AW:1] : r.waddr;
	assign mbus.wdata = r.wword;
	assign mbus.be = r.wbe;
	assign mbus.we = r.mwe;
	assign mbus.re = r.mre;

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign data_out = r.dout;
	assign data_oe = r.doe;
	assign busy_n = !r.busy;
	assign busy_oe = r.busy_oe;
endmodule

// [hpp_properties.sv]
`timescale 1ns/1ps
module hpp_properties #(
	parameter int WR_CYC = 4,
	parameter int RD_CYC = 4
) (
	// clock and reset
	input logic clk,
	input logic nrst,
	// apb
	input logic [13:0] paddr,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr,
	// host port
	input logic chip_select_n,
	input logic [15:0] adr,
	input logic byte_high_enable_n,
	input logic fetch_n,
	input logic store_n,
	input logic [15:0] data_in,
	input logic [15:0] data_out,
	input logic data_oe,
	input logic busy_n,
	input logic busy_oe
);
	localparam int BMAX = 2 * WR_CYC + RD_CYC + 24;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// synchronisers delay every release by a few cycles
	sequence s_cs_off;
		chip_select_n [*6];
	endsequence
	sequence s_rd_off;
		(chip_select_n || fetch_n) [*6];
	endsequence
	sequence s_rd_go;
		$fell(fetch_n) && !chip_select_n && !(adr[0] && byte_high_enable_n);
	endsequence
	property p_busy_rel;
		s_cs_off |-> !busy_oe;
	endproperty
	property p_busy_src;
		$rose(busy_oe) |-> !$past(chip_select_n);
	endproperty
	property p_data_rel;
		s_rd_off |-> !data_oe;
	endproperty
	property p_data_src;
		$rose(data_oe) |-> !$past(fetch_n) && !$past(chip_select_n);
	endproperty
	property p_rd_busy;
		s_rd_go |-> ##[1:5] !busy_n;
	endproperty
	property p_busy_end;
		$fell(busy_n) |-> ##[1:BMAX] busy_n;
	endproperty
	property p_hold;
		data_oe && busy_n && $past(data_oe && busy_n) |-> $stable(data_out);
	endproperty
	property p_apb_ans;
		psel && penable && !pready |=> pready;
	endproperty
	property p_apb_err;
		pslverr |-> pready && psel && penable;
	endproperty
	a_busy_rel: assert property (p_busy_rel)
		else $error("busy driver still on");
	a_busy_src: assert property (p_busy_src)
		else $error("busy driver without select");
	a_data_rel: assert property (p_data_rel)
		else $error("data bus still driven");
	a_data_src: assert property (p_data_src)
		else $error("data bus driven without read");
	a_rd_busy: assert property (p_rd_busy)
		else $error("no busy after read start");
	a_busy_end: assert property (p_busy_end)
		else $error("busy too long");
	a_hold: assert property (p_hold)
		else $error("read data changed in hold");
	a_apb_ans: assert property (p_apb_ans)
		else $error("apb answer late");
	a_apb_err: assert property (p_apb_err)
		else $error("apb error outside answer");
endmodule

// [host_model.sv]
`timescale 1ns/1ps
module host_model (
	// clock
	input logic clk,
	// device outputs
	input logic [15:0] data_out,
	input logic data_oe,
	input logic busy_n,
	input logic busy_oe,
	// host side
	output logic chip_select_n,
	output logic [15:0] adr,
	output logic byte_high_enable_n,
	output logic fetch_n,
	output logic store_n,
	output logic [15:0] data_in
);
	logic hdrv = 1'h0;
	logic [15:0] hd = 16'h0000;
	logic [15:0] prev = 16'h0000;
	int lat;
	// idle cycles after an access; zero packs accesses back to back
	int gap = 4;
	// a floating bus must not look like the last value
	assign data_in = hdrv ? hd : (data_oe ? data_out : ~prev);
	always @(posedge clk) prev <= data_in;
	initial begin
		chip_select_n = 1'h1;
		adr = 16'h0000;
		byte_high_enable_n = 1'h1;
		fetch_n = 1'h1;
		store_n = 1'h1;
	end
	// ab ends the strobe while busy, to provoke an abort
	task automatic acc(input logic wr, input logic [15:0] a, input logic bn,
		input logic [15:0] d, input logic ab, output logic [15:0] q);
		@(posedge clk);
		chip_select_n <= 1'h0;
		adr <= a;
		byte_high_enable_n <= bn;
		hd <= d;
		hdrv <= wr;
		@(posedge clk);
		if (wr) begin
			store_n <= 1'h0;
		end else begin
			fetch_n <= 1'h0;
		end
		lat = 0;
		repeat (5) @(posedge clk);
		while (!ab && busy_oe && !busy_n) begin
			@(posedge clk);
			lat++;
		end
		q = data_in;
		store_n <= 1'h1;
		fetch_n <= 1'h1;
		chip_select_n <= 1'h1;
		@(posedge clk);
		hdrv <= 1'h0;
		repeat (gap) @(posedge clk);
	endtask
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	localparam logic [13:0] A_CTRL = {hpp_pkg::IDX_PORT_CTRL, 2'h0};
	localparam logic [13:0] A_OPT = {hpp_pkg::IDX_CFG_OPT, 2'h0};
	localparam logic [13:0] A_CNT = {hpp_pkg::IDX_ERR_CNT, 2'h0};
	localparam logic [13:0] A_CODE = {hpp_pkg::IDX_ERR_CODE, 2'h0};
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, perr;
	logic [13:0] paddr;
	logic [31:0] pwdata, prdata;
	logic chip_select_n, byte_high_enable_n, fetch_n, store_n, data_oe, busy_n, busy_oe;
	logic [15:0] adr, data_in, data_out;
	logic [7:0] sh [int];
	int n_fail, compares, ecnt;
	host_parallel_port host_parallel_port_i (
		.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .chip_select_n(chip_select_n), .adr(adr),
		.byte_high_enable_n(byte_high_enable_n), .fetch_n(fetch_n), .store_n(store_n),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe), .busy_n(busy_n),
		.busy_oe(busy_oe));
	host_model host_model_i (
		.clk(clk), .data_out(data_out), .data_oe(data_oe), .busy_n(busy_n),
		.busy_oe(busy_oe), .chip_select_n(chip_select_n), .adr(adr),
		.byte_high_enable_n(byte_high_enable_n), .fetch_n(fetch_n), .store_n(store_n),
		.data_in(data_in));
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	task automatic stop_test;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		// no cycle budget here: only the watchdog ends a hung wait
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		q = prdata;
		perr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	function automatic logic [15:0] hw(input logic [15:0] a);
		return {sh[a + 16'h1], sh[a]};
	endfunction
	task automatic err_chk(input logic [7:0] c);
		logic [31:0] r;
		apb(1'h0, A_CNT, 32'h0, r);
		chk("error count", r, 32'(ecnt));
		apb(1'h0, A_CODE, 32'h0, r);
		chk("error code", r, 32'(c));
	endtask
	initial begin
		#300000;
		n_fail++;
		stop_test();
	end
	initial begin
		logic [31:0] r;
		logic [15:0] q, a, b, c, d;
		logic [7:0] e;
		int lt [4];
		nrst = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 14'h0000;
		pwdata = 32'h0;
		r = $urandom(81);
		repeat (8) @(posedge clk);
		nrst <= 1'h1;
		apb(1'h0, A_CTRL, 32'h0, r);
		chk("port type", r, 32'(hpp_pkg::PORT_CTRL_RST));
		apb(1'h1, A_CNT, 32'h5, r);
		err_chk(hpp_pkg::ERR_NONE);
		apb(1'h0, 14'h3FFC, 32'h0, r);
		chk("unmapped", 32'(perr), 32'h1);
		for (int m = 0; m < 4; m++) begin
			apb(1'h1, A_OPT, 32'(m), r);
			apb(1'h0, A_OPT, 32'h0, r);
			chk("options", r, 32'(m));
			repeat (5) begin
				a = 16'h1000 | 16'($urandom & 32'hFE);
				d = 16'($urandom);
				host_model_i.acc(1'h1, a, 1'h0, d, 1'h0, q);
				sh[a] = d[7:0];
				sh[a + 16'h1] = d[15:8];
				b = a | 16'($urandom & 32'h1);
				e = 8'($urandom);
				host_model_i.acc(1'h1, b, ~b[0], {e, e}, 1'h0, q);
				sh[b] = e;
				host_model_i.acc(1'h0, a, 1'h0, 16'h0000, 1'h0, q);
				chk("halfword", 32'(q), 32'(hw(a)));
				host_model_i.acc(1'h0, b, ~b[0], 16'h0000, 1'h0, q);
				chk("byte lanes", 32'(q), 32'({sh[b], sh[b]}));
			end
			host_model_i.acc(1'h0, a, 1'h0, 16'h0000, 1'h0, q);
			lt[m] = host_model_i.lat;
		end
		chk("read delay", 32'(lt[1] - lt[0]), 32'(hpp_pkg::RBD_CYC));
		chk("read delay rising", 32'(lt[3] - lt[2]), 32'(hpp_pkg::RBD_CYC));
		// rising-edge write with a read right behind it, before the write lands
		c = 16'h2000 | 16'($urandom & 32'hFE);
		d = 16'($urandom);
		host_model_i.gap = 0;
		host_model_i.acc(1'h1, c, 1'h0, d, 1'h0, q);
		host_model_i.acc(1'h0, c, 1'h0, 16'h0000, 1'h0, q);
		host_model_i.gap = 4;
		chk("write then read", 32'(q), 32'(d));
		chk("read waits", 32'(host_model_i.lat > lt[3]), 32'h1);
		apb(1'h1, A_OPT, 32'h0, r);
		apb(1'h1, A_CTRL, 32'(hpp_pkg::PT_NARROW), r);
		for (int i = 0; i < 2; i++) begin
			e = 8'($urandom);
			b = a | 16'(i);
			host_model_i.acc(1'h1, b, 1'h1, {~e, e}, 1'h0, q);
			sh[b] = e;
			host_model_i.acc(1'h0, b, 1'h1, 16'h0000, 1'h0, q);
			chk("narrow byte", 32'(q[7:0]), 32'(e));
		end
		apb(1'h1, A_CTRL, 32'(hpp_pkg::PT_WIDE), r);
		host_model_i.acc(1'h0, a, 1'h0, 16'h0000, 1'h0, q);
		chk("narrow pair", 32'(q), 32'(hw(a)));
		for (int w = 1; w >= 0; w--) begin
			host_model_i.acc(w[0], a | 16'h1, 1'h1, 16'hFFFF, 1'h0, q);
			ecnt++;
			err_chk(hpp_pkg::ERR_ODD_NO_BHE);
		end
		host_model_i.acc(1'h0, a, 1'h0, 16'h0000, 1'h0, q);
		chk("no access", 32'(q), 32'(hw(a)));
		host_model_i.acc(1'h1, a, 1'h0, 16'h0F0F, 1'h1, q);
		ecnt++;
		err_chk(hpp_pkg::ERR_WR_ABORT);
		host_model_i.acc(1'h0, a, 1'h0, 16'h0000, 1'h1, q);
		ecnt++;
		err_chk(hpp_pkg::ERR_RD_ABORT);
		stop_test();
	end
endmodule
bind host_parallel_port hpp_properties #(.WR_CYC(WR_CYC), .RD_CYC(RD_CYC)) hpp_properties_i (
	.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .chip_select_n(chip_select_n), .adr(adr),
	.byte_high_enable_n(byte_high_enable_n), .fetch_n(fetch_n), .store_n(store_n),
	.data_in(data_in), .data_out(data_out), .data_oe(data_oe), .busy_n(busy_n),
	.busy_oe(busy_oe));
